//--- shared/hbs_pkg.sv
// Package with constants and types of the holding brake sequencer
package hbs_pkg;

  // ********************************************************************
  // Clock and time base
  // ********************************************************************
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / MS_PER_S * TICK_MS;

  // ********************************************************************
  // Setting ranges and defaults
  // ********************************************************************
  localparam logic [1:0]  CFG_NONE      = 2'h0;
  localparam logic [1:0]  CFG_SEQUENCE  = 2'h1;
  localparam logic [1:0]  CFG_ALWAYS    = 2'h2;
  localparam logic [1:0]  CFG_RESET     = 2'h0;
  localparam int unsigned DELAY_MAX_MS  = 10000;
  localparam int unsigned SPEED_MAX_RPM = 210000;
  localparam int unsigned SPEED_DEF_RPM = 20;
  localparam int unsigned MON_MAX_S     = 300;
  localparam int unsigned MON_DEF_S     = 300;
  localparam int unsigned SUP_MAX_S     = 299;
  localparam int unsigned SUP_DEF_S     = 0;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [3:0] REG_CONFIG     = 4'h0;
  localparam logic [3:0] REG_OPEN_DLY   = 4'h1;
  localparam logic [3:0] REG_CLOSE_DLY  = 4'h2;
  localparam logic [3:0] REG_SPEED_THR  = 4'h3;
  localparam logic [3:0] REG_MON_TIME   = 4'h4;
  localparam logic [3:0] REG_SUP_DELAY  = 4'h5;
  localparam logic [3:0] REG_STATUS     = 4'h6;
  localparam logic [3:0] REG_MOTOR_INFO = 4'h7;

  localparam int unsigned DLY_W         = 14;
  localparam int unsigned SPD_W         = 18;
  localparam int unsigned SEC_W         = 9;
  localparam int unsigned MS_W          = 19;

  // Gray-coded along idle -> opening -> running -> stopping -> closing
  typedef enum logic [2:0] {
    ST_ENGAGED  = 3'h0,
    ST_OPENING  = 3'h1,
    ST_RUNNING  = 3'h3,
    ST_STOPPING = 3'h2,
    ST_CLOSING  = 3'h6
  } hbs_state_type;

endpackage

//--- design/hbs_tick.sv
// Millisecond tick generator
`timescale 1ns/1ps
module hbs_tick #(
  parameter int unsigned CYCLES = hbs_pkg::TICK_CYCLES
) (
  input  wire logic mclk,  // System clock
  input  wire logic rst_n, // Synchronised reset
  output logic      tick   // One-cycle pulse every period
);
  logic [17:0] count;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 18'h0;
      tick  <= 1'b0;
    end
    else if (count == 18'(CYCLES - 1))
    begin
      count <= 18'h0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 18'h1;
      tick  <= 1'b0;
    end
  end
endmodule

//--- design/hbs_timer.sv
// Loadable down counter advanced by a tick
`timescale 1ns/1ps
module hbs_timer #(
  parameter int unsigned W = 19
) (
  input  wire logic         mclk,  // System clock
  input  wire logic         rst_n, // Synchronised reset
  input  wire logic         load,  // Start with new value
  input  wire logic         stop,  // Abandon the count
  input  wire logic [W-1:0] value, // Count in ticks
  input  wire logic         tick,  // Time base
  output logic              done   // Level: count reached zero
);
  logic [W-1:0] count;
  logic         active;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count  <= '0;
      active <= 1'b0;
    end
    else if (load)
    begin
      count  <= value;
      active <= 1'b1;
    end
    else if (stop)
      active <= 1'b0;
    else if (active && tick && count != '0)
      count <= count - 1'b1;
  end

  // A zero setting finishes one cycle after the load
  assign done = active && !load && count == '0;
endmodule

//--- design/hbs_top.sv
// Holding brake sequencer: settings, sequence and brake output
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Behaviour
// - Configuration accepts 0 none, 1 sequence controlled, 2 always released.
// - Configuration 2 keeps brake released regardless of drive state.
// - Configuration 1 releases on drive on rising edge, engages at servo off; here only while principle is set, else the brake stays released.
// - Opening delay 0 to 10000 ms applied on release.
// - Closing delay 0 to 10000 ms applied on engagement.
// - Delay reset values follow the motor rated power.
// - Standstill speed threshold 0 to 210000 rpm, default 20.
// - Standstill monitoring time 0 to 300 s, default 300.
// - Pulse suppression delay 0 to 299 s, default 0.
// - Closing delay starts at standstill or at the earlier of monitor or suppression expiry.
// - Absolute encoder sets principle automatically; incremental uses motor selection.
// - Brake output high engages, low releases.
module hbs_top #(
  parameter logic [13:0] OPEN_DLY_LOW   = 14'h64,  // Default for small motors, ms
  parameter logic [13:0] OPEN_DLY_HIGH  = 14'hc8,  // Default for large motors, ms
  parameter logic [13:0] CLOSE_DLY_LOW  = 14'h32,
  parameter logic [13:0] CLOSE_DLY_HIGH = 14'h64,
  parameter logic [7:0]  POWER_SPLIT    = 8'h0a,   // Rated power class boundary
  parameter int unsigned TICK_CYCLES    = hbs_pkg::TICK_CYCLES
) (
  input  wire logic        mclk,               // 200 MHz clock
  input  wire logic        nrst,               // Asynchronous reset, active low
  input  wire logic [3:0]  addr,               // Register index
  input  wire logic [31:0] wdata,              // Write data
  input  wire logic        wr,                 // Write strobe
  input  wire logic        rd,                 // Read strobe
  output logic      [31:0] rdata,              // Read data, cycle after rd
  input  wire logic        drive_on_command,   // Drive on control bit, async
  input  wire logic        servo_off,          // Motor reached servo off, async
  input  wire logic [17:0] motor_speed,        // Absolute speed, rpm
  input  wire logic [7:0]  motor_power_class,  // Rated power class of motor
  input  wire logic        encoder_absolute,   // Absolute encoder fitted
  input  wire logic        brake_principle_sel,// Brake principle from motor selection
  output logic             brake_engage_output,// High engages the brake
  output logic             motion_enable,      // Release motion after opening
  output logic             pulse_suppress      // Suppress motor pulses
);

  // ********************************************************************
  // Reset and input synchronisers
  // ********************************************************************
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] on_sync;
  logic [1:0] off_sync;
  logic       on_prev;
  logic       on_rise;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_sync  <= 2'h0;
      off_sync <= 2'h3;
      on_prev  <= 1'b0;
    end
    else
    begin
      on_sync  <= {on_sync[0], drive_on_command};
      off_sync <= {off_sync[0], servo_off};
      on_prev  <= on_sync[1];
    end
  end
  assign on_rise = on_sync[1] && !on_prev;

  // ********************************************************************
  // Settings
  // ********************************************************************
  logic [1:0]                  brake_config_select;
  logic [hbs_pkg::DLY_W-1:0]   brake_open_delay;
  logic [hbs_pkg::DLY_W-1:0]   brake_close_delay;
  logic [hbs_pkg::SPD_W-1:0]   standstill_speed_threshold;
  logic [hbs_pkg::SEC_W-1:0]   standstill_monitor_time;
  logic [hbs_pkg::SEC_W-1:0]   pulse_suppress_delay;
  logic                        delays_loaded;
  logic                        principle;
  hbs_pkg::hbs_state_type      state;
  // Out of range writes are ignored so the settings always stay legal
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brake_config_select        <= hbs_pkg::CFG_RESET;
      standstill_speed_threshold <= hbs_pkg::SPD_W'(hbs_pkg::SPEED_DEF_RPM);
      standstill_monitor_time    <= hbs_pkg::SEC_W'(hbs_pkg::MON_DEF_S);
      pulse_suppress_delay       <= hbs_pkg::SEC_W'(hbs_pkg::SUP_DEF_S);
    end
    else if (wr)
      case (addr)
        hbs_pkg::REG_CONFIG:
          if (wdata <= 32'(hbs_pkg::CFG_ALWAYS))
            brake_config_select <= wdata[1:0];
        hbs_pkg::REG_SPEED_THR:
          if (wdata <= hbs_pkg::SPEED_MAX_RPM)
            standstill_speed_threshold <= wdata[hbs_pkg::SPD_W-1:0];
        hbs_pkg::REG_MON_TIME:
          if (wdata <= hbs_pkg::MON_MAX_S)
            standstill_monitor_time <= wdata[hbs_pkg::SEC_W-1:0];
        hbs_pkg::REG_SUP_DELAY:
          if (wdata <= hbs_pkg::SUP_MAX_S)
            pulse_suppress_delay <= wdata[hbs_pkg::SEC_W-1:0];
        default: ;
      endcase
  end
  // Delay defaults are caught from the motor class on the first cycle after reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brake_open_delay  <= '0;
      brake_close_delay <= '0;
      delays_loaded     <= 1'b0;
    end
    else if (!delays_loaded)
    begin
      delays_loaded     <= 1'h1;
      brake_open_delay  <= motor_power_class >= POWER_SPLIT ? OPEN_DLY_HIGH : OPEN_DLY_LOW;
      brake_close_delay <= motor_power_class >= POWER_SPLIT ? CLOSE_DLY_HIGH : CLOSE_DLY_LOW;
    end
    else if (wr && addr == hbs_pkg::REG_OPEN_DLY && wdata <= hbs_pkg::DELAY_MAX_MS)
      brake_open_delay <= wdata[hbs_pkg::DLY_W-1:0];
    else if (wr && addr == hbs_pkg::REG_CLOSE_DLY && wdata <= hbs_pkg::DELAY_MAX_MS)
      brake_close_delay <= wdata[hbs_pkg::DLY_W-1:0];
  end
  // Absolute encoders use the sequence principle; incremental take the selection
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      principle <= 1'b0;
    else
      principle <= encoder_absolute ? 1'b1 : brake_principle_sel;
  end

  // ********************************************************************
  // Timers
  // ********************************************************************
  logic tick;
  logic open_done;
  logic close_done;
  logic mon_done;
  logic sup_done;
  logic start_open;
  logic start_off;
  logic start_close;
  logic seq_mode;
  logic standstill;
  hbs_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (tick)
  );
  assign seq_mode    = brake_config_select == hbs_pkg::CFG_SEQUENCE && principle;
  assign standstill  = motor_speed <= standstill_speed_threshold;
  assign start_open  = state == hbs_pkg::ST_ENGAGED && seq_mode && on_rise;
  assign start_off   = state == hbs_pkg::ST_RUNNING && off_sync[1];
  // the earlier of the two timers, or standstill seen, starts closing
  assign start_close = state == hbs_pkg::ST_STOPPING && (mon_done || sup_done || standstill);
  hbs_timer #(.W(hbs_pkg::MS_W)) u_open (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (start_open),
    .stop  (state != hbs_pkg::ST_OPENING),
    .value (hbs_pkg::MS_W'(brake_open_delay)),
    .tick  (tick),
    .done  (open_done)
  );
  hbs_timer #(.W(hbs_pkg::MS_W)) u_close (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (start_close),
    .stop  (state != hbs_pkg::ST_CLOSING),
    .value (hbs_pkg::MS_W'(brake_close_delay)),
    .tick  (tick),
    .done  (close_done)
  );
  hbs_timer #(.W(hbs_pkg::MS_W)) u_mon (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (start_off),
    .stop  (state != hbs_pkg::ST_STOPPING),
    .value (hbs_pkg::MS_W'(standstill_monitor_time * hbs_pkg::MS_PER_S)),
    .tick  (tick),
    .done  (mon_done)
  );
  hbs_timer #(.W(hbs_pkg::MS_W)) u_sup (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (start_off),
    .stop  (state != hbs_pkg::ST_STOPPING),
    .value (hbs_pkg::MS_W'(pulse_suppress_delay * hbs_pkg::MS_PER_S)),
    .tick  (tick),
    .done  (sup_done)
  );

  // ********************************************************************
  // Sequence
  // ********************************************************************
  hbs_pkg::hbs_state_type next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      hbs_pkg::ST_ENGAGED:
        if (start_open)
          next_state = hbs_pkg::ST_OPENING;
      hbs_pkg::ST_OPENING:
        if (off_sync[1])
          next_state = hbs_pkg::ST_ENGAGED;
        else if (open_done)
          next_state = hbs_pkg::ST_RUNNING;
      hbs_pkg::ST_RUNNING:
        if (start_off)
          next_state = hbs_pkg::ST_STOPPING;
      hbs_pkg::ST_STOPPING:
        if (start_close)
          next_state = hbs_pkg::ST_CLOSING;
      hbs_pkg::ST_CLOSING:
        if (close_done)
          next_state = hbs_pkg::ST_ENGAGED;
      default: next_state = hbs_pkg::ST_ENGAGED;
    endcase
    // Leaving sequence mode drops the sequence back to its rest state
    if (!seq_mode)
      next_state = hbs_pkg::ST_ENGAGED;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= hbs_pkg::ST_ENGAGED;
    else
      state <= next_state;
  end
  // Brake stays released until the closing delay ends, or until servo off during the opening delay
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      brake_engage_output <= 1'b1;
    else if (brake_config_select == hbs_pkg::CFG_ALWAYS)
      brake_engage_output <= 1'b0;
    else if (brake_config_select == hbs_pkg::CFG_NONE || !seq_mode)
      brake_engage_output <= 1'b0;
    else
      brake_engage_output <= next_state == hbs_pkg::ST_ENGAGED;
  end
  // Outside sequence mode: motion follows the drive on command, cleared by servo off
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motion_enable  <= 1'b0;
      pulse_suppress <= 1'b1;
    end
    else if (!seq_mode)
    begin
      motion_enable  <= on_sync[1] && !off_sync[1];
      pulse_suppress <= !on_sync[1];
    end
    else
    begin
      motion_enable  <= next_state == hbs_pkg::ST_RUNNING;
      pulse_suppress <= next_state == hbs_pkg::ST_ENGAGED;
    end
  end

  // ********************************************************************
  // Register read
  // ********************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (rd)
      case (addr)
        hbs_pkg::REG_CONFIG:     rdata <= {30'h0, brake_config_select};
        hbs_pkg::REG_OPEN_DLY:   rdata <= {18'h0, brake_open_delay};
        hbs_pkg::REG_CLOSE_DLY:  rdata <= {18'h0, brake_close_delay};
        hbs_pkg::REG_SPEED_THR:  rdata <= {14'h0, standstill_speed_threshold};
        hbs_pkg::REG_MON_TIME:   rdata <= {23'h0, standstill_monitor_time};
        hbs_pkg::REG_SUP_DELAY:  rdata <= {23'h0, pulse_suppress_delay};
        hbs_pkg::REG_STATUS:     rdata <= {25'h0, principle, pulse_suppress,
                                           motion_enable, brake_engage_output, state};
        hbs_pkg::REG_MOTOR_INFO: rdata <= {23'h0, encoder_absolute, motor_power_class};
        default:                 rdata <= 32'h0;
      endcase
    else
      rdata <= 32'h0;
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  chk_always_open: assert property (@(posedge mclk) disable iff (!rst_n)
    brake_config_select == hbs_pkg::CFG_ALWAYS |=> !brake_engage_output)
    else $error("brake engaged in always released mode");
  chk_open_waits: assert property (@(posedge mclk) disable iff (!rst_n)
    state == hbs_pkg::ST_OPENING |-> !motion_enable)
    else $error("motion enabled during opening delay");
  chk_release_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    start_open |=> !brake_engage_output)
    else $error("brake not released after drive on edge");
  chk_engage_rest: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_mode && $past(seq_mode) && state == hbs_pkg::ST_ENGAGED && !$past(start_open)
    |-> brake_engage_output)
    else $error("brake released while sequence at rest");
  chk_close_start: assert property (@(posedge mclk) disable iff (!rst_n)
    state == hbs_pkg::ST_STOPPING && seq_mode && (mon_done || sup_done)
    |=> state == hbs_pkg::ST_CLOSING || !seq_mode)
    else $error("closing delay not started after timer expiry");
  chk_cfg_range: assert property (@(posedge mclk) disable iff (!rst_n)
    brake_config_select <= hbs_pkg::CFG_ALWAYS)
    else $error("brake configuration out of range");
  chk_open_range: assert property (@(posedge mclk) disable iff (!rst_n)
    delays_loaded |-> brake_open_delay <= hbs_pkg::DLY_W'(hbs_pkg::DELAY_MAX_MS))
    else $error("opening delay out of range");
  chk_close_range: assert property (@(posedge mclk) disable iff (!rst_n)
    delays_loaded |-> brake_close_delay <= hbs_pkg::DLY_W'(hbs_pkg::DELAY_MAX_MS))
    else $error("closing delay out of range");
  chk_pulse_off: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_mode && $past(seq_mode) && close_done && state == hbs_pkg::ST_CLOSING
    |=> pulse_suppress && brake_engage_output)
    else $error("pulses not suppressed after closing delay");

endmodule

//--- sim/hbs_brake_model.sv
// Behavioural holding brake with its relay, driven by the sequencer output
`timescale 1ns/1ps
module hbs_brake_model #(
  parameter int unsigned RELAY_CYCLES = 4  // Relay pick-up and drop-out time
) (
  input  wire logic mclk,                // System clock
  input  wire logic brake_engage_output, // High engages the brake
  output logic      shaft_free           // High while the shaft may turn
);
  int unsigned cnt = 0;

  initial shaft_free = 1'h0;

  // The shaft only follows once the relay has settled, so a short glitch never frees it
  always @(posedge mclk)
  begin
    if (shaft_free == !brake_engage_output)
      cnt <= 0;
    else if (cnt == RELAY_CYCLES - 1)
    begin
      shaft_free <= !brake_engage_output;
      cnt        <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

//--- sim/testbench.sv
// Self-checking testbench of the holding brake sequencer
`timescale 1ns/1ps
module testbench;
  localparam logic [13:0] OPEN_LO  = 14'h64;
  localparam logic [13:0] OPEN_HI  = 14'hc8;
  localparam logic [13:0] CLOSE_LO = 14'h32;
  localparam logic [13:0] CLOSE_HI = 14'h64;
  localparam int unsigned TICK     = 4;
  localparam int unsigned LIMIT    = 20000;

  logic        mclk;
  logic        nrst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        drive_on_command;
  logic        servo_off;
  logic [17:0] motor_speed;
  logic [7:0]  motor_power_class;
  logic        encoder_absolute;
  logic        brake_principle_sel;
  logic        brake_engage_output;
  logic        motion_enable;
  logic        pulse_suppress;
  logic        shaft_free;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  hbs_top #(
    .OPEN_DLY_LOW   (OPEN_LO),
    .OPEN_DLY_HIGH  (OPEN_HI),
    .CLOSE_DLY_LOW  (CLOSE_LO),
    .CLOSE_DLY_HIGH (CLOSE_HI),
    .POWER_SPLIT    (8'h0a),
    .TICK_CYCLES    (TICK)
  ) uut (
    .mclk                (mclk),
    .nrst                (nrst),
    .addr                (addr),
    .wdata               (wdata),
    .wr                  (wr),
    .rd                  (rd),
    .rdata               (rdata),
    .drive_on_command    (drive_on_command),
    .servo_off           (servo_off),
    .motor_speed         (motor_speed),
    .motor_power_class   (motor_power_class),
    .encoder_absolute    (encoder_absolute),
    .brake_principle_sel (brake_principle_sel),
    .brake_engage_output (brake_engage_output),
    .motion_enable       (motion_enable),
    .pulse_suppress      (pulse_suppress)
  );

  hbs_brake_model #(
    .RELAY_CYCLES (4)
  ) brake (
    .mclk                (mclk),
    .brake_engage_output (brake_engage_output),
    .shaft_free          (shaft_free)
  );

  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge mclk);
    wr    <= 1'h0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge mclk);
    rd   <= 1'h0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_rd(a, d);
    check($sformatf("reg_%0h", a), d, e);
  endtask

  function automatic logic sig_of(input int w);
    return (w == 0) ? brake_engage_output : motion_enable;
  endfunction

  // Bounded wait, so a stuck output shows as a count rather than a hang
  task automatic wait_for(input int w, input logic v, input int max, output int n);
    n = 0;
    while (sig_of(w) !== v && n < max)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] rv [6];
    rv = '{32'h0, {18'h0, OPEN_LO}, {18'h0, CLOSE_LO}, 32'h14, 32'h12c, 32'h0};
    for (int i = 0; i < 6; i++)
      rd_chk(i[3:0], rv[i]);
    rd_chk(4'h7, 32'h105);
    check("brake_cfg_none", brake_engage_output, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_refuse;
    logic [31:0] mx [6];
    logic [31:0] d;
    mx = '{32'h2, 32'h2710, 32'h2710, 32'h33450, 32'h12c, 32'h12b};
    for (int i = 0; i < 6; i++)
    begin
      reg_rd(i[3:0], d);
      reg_wr(i[3:0], mx[i] + 32'h1);
      rd_chk(i[3:0], d);
      reg_wr(i[3:0], mx[i]);
      rd_chk(i[3:0], mx[i]);
    end
    reg_wr(4'h7, 32'h0);
    rd_chk(4'h7, 32'h105);
    rd_chk(4'h8, 32'h0);
    $display("test refuse done");
  endtask

  task automatic t_always;
    int hits;
    hits = 0;
    reg_wr(4'h0, 32'h2);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge mclk);
      drive_on_command <= i[2];
      servo_off        <= i[3];
      #1;
      if (brake_engage_output !== 1'h0)
        hits++;
    end
    check("always_open", hits, 32'h0);
    @(posedge mclk);
    drive_on_command <= 1'h0;
    servo_off        <= 1'h0;
    $display("test always done");
  endtask

  // Open with 2 ms, close with 3 ms; lo and hi bound the stop-to-engage time
  task automatic run_cycle(input logic [31:0] mon, input logic [31:0] sup,
                           input logic [17:0] spd, input int lo, input int hi);
    int          n;
    logic [31:0] d;
    reg_wr(4'h0, 32'h1);
    reg_wr(4'h1, 32'h2);
    reg_wr(4'h2, 32'h3);
    reg_wr(4'h3, 32'h14);
    reg_wr(4'h4, mon);
    reg_wr(4'h5, sup);
    motor_speed <= 18'h64;
    repeat (2) @(posedge mclk);
    #1;
    check("brake_idle", brake_engage_output, 32'h1);
    @(posedge mclk);
    drive_on_command <= 1'h1;
    wait_for(0, 1'h0, 20, n);
    check("release_time", (n <= 6), 32'h1);
    check("motion_early", motion_enable, 32'h0);
    wait_for(1, 1'h1, 40, n);
    check("open_delay", (n >= 3 && n <= 14), 32'h1);
    reg_rd(4'h6, d);
    check("status_run", d, 32'h53);
    check("shaft_free", shaft_free, 32'h1);
    @(posedge mclk);
    motor_speed <= spd;
    servo_off   <= 1'h1;
    wait_for(0, 1'h1, 6000, n);
    check("close_time", (n >= lo && n <= hi), 32'h1);
    check("pulses_off", pulse_suppress, 32'h1);
    check("motion_off", motion_enable, 32'h0);
    @(posedge mclk);
    drive_on_command <= 1'h0;
    servo_off        <= 1'h0;
    repeat (4) @(posedge mclk);
    $display("test run_cycle done");
  endtask

  task automatic t_incremental;
    logic [31:0] d;
    @(posedge mclk);
    encoder_absolute    <= 1'h0;
    brake_principle_sel <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    check("brake_plain", brake_engage_output, 32'h0);
    @(posedge mclk);
    drive_on_command <= 1'h1;
    repeat (6) @(posedge mclk);
    #1;
    check("motion_plain", motion_enable, 32'h1);
    check("pulses_plain", pulse_suppress, 32'h0);
    reg_rd(4'h6, d);
    check("principle_off", d[6], 32'h0);
    @(posedge mclk);
    drive_on_command    <= 1'h0;
    brake_principle_sel <= 1'h1;
    repeat (4) @(posedge mclk);
    run_cycle(32'h2, 32'h2, 18'h0, 8, 24);
    $display("test incremental done");
  endtask

  // A second reset in mid-run with a large motor picks the other delay defaults
  task automatic t_power;
    @(posedge mclk);
    nrst              <= 1'h0;
    motor_power_class <= 8'hc8;
    repeat (3) @(posedge mclk);
    #1;
    check("brake_in_reset", brake_engage_output, 32'h1);
    check("motion_in_reset", motion_enable, 32'h0);
    check("pulse_in_reset", pulse_suppress, 32'h1);
    @(posedge mclk);
    nrst <= 1'h1;
    repeat (5) @(posedge mclk);
    rd_chk(4'h1, {18'h0, OPEN_HI});
    rd_chk(4'h2, {18'h0, CLOSE_HI});
    $display("test power done");
  endtask

  initial
  begin
    nrst                = 1'h0;
    addr                = 4'h0;
    wdata               = 32'h0;
    wr                  = 1'h0;
    rd                  = 1'h0;
    drive_on_command    = 1'h0;
    servo_off           = 1'h0;
    motor_speed         = 18'h0;
    motor_power_class   = 8'h05;
    encoder_absolute    = 1'h1;
    brake_principle_sel = 1'h0;
    repeat (8) @(posedge mclk);
    nrst <= 1'h1;
    repeat (5) @(posedge mclk);
    t_reset;
    t_refuse;
    t_always;
    run_cycle(32'h2, 32'h1, 18'h64, 4000, 4030);
    run_cycle(32'h1, 32'h2, 18'h64, 4000, 4030);
    t_incremental;
    t_power;
    end_of_test;
  end
endmodule
